// ===== common/gpc_pkg.sv
package gpc_pkg;

	// =====================================================================
	// Register map
	localparam logic [7:0]  GPC_CTRL_OFS      = 8'h00;
	localparam logic [7:0]  GPC_COUNT_OFS     = 8'h04;
	localparam logic [7:0]  GPC_LAST_ERR_OFS  = 8'h08;
	localparam logic [7:0]  GPC_LAST_CAUSE_OFS = 8'h0c;
	localparam int          GPC_CTRL_EN_BIT   = 0;
	localparam logic        GPC_CTRL_RST      = 1'b1;

	// =====================================================================
	// Fault report
	localparam logic [7:0]  GPC_VECTOR        = 8'h0d;
	localparam logic [4:0]  GPC_MAX_LEN       = 5'h0f;
	localparam logic [31:0] GPC_ERR_NONE      = 32'h0000_0000;
	localparam logic [2:0]  GPC_ERR_IDT_FLAG  = 3'h2;

	// =====================================================================
	// Control register fields
	localparam int          GPC_CR0_PE        = 0;
	localparam int          GPC_CR0_NW        = 29;
	localparam int          GPC_CR0_CD        = 30;
	localparam int          GPC_CR0_PG        = 31;
	localparam logic [63:0] GPC_CR4_RSVD      = 64'hffff_ffff_ff88_f000;
	localparam logic [63:0] GPC_VCSR_RSVD     = 64'hffff_ffff_ffff_0000;

	// =====================================================================
	// Gate descriptor types and alignment
	localparam logic [3:0]  GPC_GATE_TASK     = 4'h5;
	localparam logic [3:0]  GPC_GATE_INT16    = 4'h6;
	localparam logic [3:0]  GPC_GATE_TRAP16   = 4'h7;
	localparam logic [3:0]  GPC_GATE_INT      = 4'he;
	localparam logic [3:0]  GPC_GATE_TRAP     = 4'hf;
	localparam logic [3:0]  GPC_ALIGN_MASK    = 4'hf;
	localparam int          GPC_VA_BITS       = 48;
	localparam int          GPC_NCAUSE        = 22;

	// =====================================================================
	// Control register selector and segment targets
	typedef enum logic [1:0] {
		GPC_CR_CR0  = 2'b00,
		GPC_CR_CR4  = 2'b01,
		GPC_CR_MSR  = 2'b10,
		GPC_CR_VCSR = 2'b11
	} gpc_cr_t;

	typedef enum logic [1:0] {
		GPC_LD_DATA = 2'b00,
		GPC_LD_SS   = 2'b01,
		GPC_LD_CS   = 2'b10,
		GPC_LD_NONE = 2'b11
	} gpc_ld_t;

endpackage : gpc_pkg

// ===== common/gpc_canon_if.sv
`timescale 1ns/1ps
interface gpc_canon_if;
	logic [63:0] addr;
	logic        chk;
	logic        bad;
	modport chk_side (input addr, input chk, output bad);
	modport user     (output addr, output chk, input bad);
endinterface : gpc_canon_if

// ===== verilog/gpc_canon_chk.sv
`timescale 1ns/1ps
module gpc_canon_chk
	import gpc_pkg::*;
#(
	parameter int VA_BITS = GPC_VA_BITS
) (
	gpc_canon_if.chk_side c
);
	// =====================================================================
	// Upper bits must all copy the top implemented address bit
	logic [63-VA_BITS+1:0] top;

	always_comb begin
		top   = c.addr[63:VA_BITS-1];
		c.bad = c.chk && !((&top) || !(|top));
	end

endmodule : gpc_canon_chk

// ===== verilog/gpc_checker.sv
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module gpc_checker
	import gpc_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite register slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Check request and processor context
	input  wire logic        req_valid,
	input  wire logic        other_fault,
	input  wire logic [1:0]  current_privilege_level,
	input  wire logic        mode_64,
	input  wire logic        long_mode_active,
	input  wire logic [15:0] insn_cs,
	input  wire logic [63:0] insn_ip,
	input  wire logic [4:0]  insn_len,
	input  wire logic        privileged_insn,
	// Memory access through a segment
	input  wire logic        acc_valid,
	input  wire logic        acc_via_ss,
	input  wire logic        acc_write,
	input  wire logic        acc_over_limit,
	input  wire logic        acc_seg_code,
	input  wire logic        acc_seg_writable,
	input  wire logic        acc_seg_readable,
	input  wire logic        acc_seg_null,
	input  wire logic [63:0] acc_addr,
	input  wire logic        acc_vec_aligned,
	// Segment register load and descriptor fetch
	input  wire gpc_ld_t     ld_target,
	input  wire logic        ld_null,
	input  wire logic        ld_desc_exec,
	input  wire logic [15:0] desc_selector,
	input  wire logic        desc_addr_valid,
	input  wire logic [63:0] desc_addr,
	// Control register writes
	input  wire logic        cr_wr_valid,
	input  wire gpc_cr_t     cr_sel,
	input  wire logic [63:0] cr_wdata,
	input  wire logic [63:0] msr_rsvd_mask,
	// Interrupts, gates and far transfers
	input  wire logic        swint_insn,
	input  wire logic [1:0]  swint_gate_dpl,
	input  wire logic        dlv_valid,
	input  wire logic [7:0]  dlv_vector,
	input  wire logic [3:0]  dlv_gate_type,
	input  wire logic        interrupt_return_instruction,
	input  wire logic        nested_task_flag,
	input  wire logic        gate64_valid,
	input  wire logic [4:0]  gate64_upper_type,
	input  wire logic [1:0]  gate64_dpl,
	input  wire logic [1:0]  gate64_rpl,
	input  wire logic        far_valid,
	input  wire logic [63:0] far_offset,
	input  wire logic        far_tgt_long,
	input  wire logic        far_tgt_dsize,
	// Task switch
	input  wire logic        ts_active,
	input  wire logic        ts_committed,
	// Fault report
	output logic             general_protection_fault,
	output logic [7:0]       flt_vector,
	output logic             flt_errcode_valid,
	output logic [31:0]      flt_errcode,
	output logic [15:0]      flt_cs,
	output logic [63:0]      flt_ip,
	output logic             flt_load_new_task
);

	// =====================================================================
	// State
	typedef struct packed {
		logic                  aw_held;
		logic [7:0]            aw_addr;
		logic                  w_held;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [1:0]            rresp;
		logic [31:0]           rdata;
		logic                  enable;
		logic [31:0]           count;
		logic [31:0]           last_err;
		logic [GPC_NCAUSE-1:0] last_cause;
		logic                  flt;
		logic [31:0]           err;
		logic [15:0]           cs;
		logic [63:0]           ip;
		logic                  new_task;
	} gpc_state_t;

	gpc_state_t st_r;
	gpc_state_t st_nxt;

	// =====================================================================
	// Canonical checks: memory, descriptor and far target addresses
	gpc_canon_if cif[3] ();
	logic [2:0] canon_bad;

	assign cif[0].addr = acc_addr;
	assign cif[0].chk  = mode_64 && acc_valid;
	assign cif[1].addr = desc_addr;
	assign cif[1].chk  = mode_64 && desc_addr_valid;
	assign cif[2].addr = far_offset;
	assign cif[2].chk  = mode_64 && far_valid;

	generate
		for (genvar i = 0; i < 3; i++) begin : g_canon
			gpc_canon_chk u_chk (.c(cif[i]));
			assign canon_bad[i] = cif[i].bad;
		end
	endgenerate

	// =====================================================================
	// Violation detection
	logic [GPC_NCAUSE-1:0] cause;
	logic                  data_reg;
	logic                  gate_ok;
	logic                  desc_cause;
	logic                  dlv_cause;
	logic                  raise;

	always_comb begin
		data_reg = !acc_via_ss;
		gate_ok  = dlv_gate_type inside {GPC_GATE_TASK, GPC_GATE_INT16,
			GPC_GATE_TRAP16, GPC_GATE_INT, GPC_GATE_TRAP};
		cause = '0;
		cause[0]  = acc_valid && data_reg && acc_over_limit;
		cause[1]  = acc_valid && acc_write
			&& (acc_seg_code || !acc_seg_writable);
		cause[2]  = acc_valid && !acc_write && acc_seg_code
			&& !acc_seg_readable;
		cause[3]  = ld_target == GPC_LD_SS && (ld_desc_exec || ld_null);
		cause[4]  = ld_target == GPC_LD_CS && (!ld_desc_exec || ld_null);
		cause[5]  = acc_valid && data_reg && acc_seg_null;
		cause[6]  = insn_len > GPC_MAX_LEN;
		cause[7]  = cr_wr_valid && cr_sel == GPC_CR_CR0
			&& cr_wdata[GPC_CR0_PG] && !cr_wdata[GPC_CR0_PE];
		cause[8]  = cr_wr_valid && cr_sel == GPC_CR_CR0
			&& cr_wdata[GPC_CR0_NW] && !cr_wdata[GPC_CR0_CD];
		cause[9]  = cr_wr_valid && cr_sel == GPC_CR_CR4
			&& |(cr_wdata & GPC_CR4_RSVD);
		cause[10] = cr_wr_valid && cr_sel == GPC_CR_MSR
			&& |(cr_wdata & msr_rsvd_mask);
		cause[11] = cr_wr_valid && cr_sel == GPC_CR_VCSR
			&& |(cr_wdata & GPC_VCSR_RSVD);
		cause[12] = privileged_insn && current_privilege_level != 2'h0;
		cause[13] = swint_insn && swint_gate_dpl < current_privilege_level;
		cause[14] = dlv_valid && !gate_ok;
		cause[15] = acc_valid && acc_vec_aligned
			&& |(acc_addr[3:0] & GPC_ALIGN_MASK);
		cause[16] = |canon_bad;
		cause[17] = mode_64 && interrupt_return_instruction
			&& nested_task_flag;
		cause[18] = gate64_valid && (gate64_upper_type != 5'h00
			|| gate64_dpl < current_privilege_level
			|| gate64_dpl < gate64_rpl);
		cause[19] = far_valid && far_tgt_long && far_tgt_dsize;
		cause[20] = cr_wr_valid && cr_sel == GPC_CR_CR0
			&& long_mode_active && !cr_wdata[GPC_CR0_PG];
		cause[21] = 1'b0;
		desc_cause = |{cause[3], cause[4], cause[18], cause[19]};
		dlv_cause  = cause[14];
		// More specific exception classes take the event instead
		raise = st_r.enable && req_valid && !other_fault && |cause;
	end

	// =====================================================================
	// Next state
	logic aw_go;
	logic w_go;
	logic ar_go;
	logic wr_hit;

	always_comb begin
		st_nxt = st_r;
		aw_go  = s_axi_awvalid && !st_r.aw_held && !st_r.bvalid;
		w_go   = s_axi_wvalid && !st_r.w_held && !st_r.bvalid;
		ar_go  = s_axi_arvalid && !st_r.rvalid;
		wr_hit = 1'b0;
		if (aw_go) begin
			st_nxt.aw_held = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end
		if (w_go) begin
			st_nxt.w_held = 1'b1;
			st_nxt.w_data = s_axi_wdata;
			st_nxt.w_strb = s_axi_wstrb;
		end
		// Write acts once address and data are both in, any order
		if (st_r.aw_held && st_r.w_held) begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held  = 1'b0;
			st_nxt.bvalid  = 1'b1;
			st_nxt.bresp   = 2'b00;
			unique case (st_r.aw_addr[7:2])
				GPC_CTRL_OFS[7:2]: begin
					if (st_r.w_strb[0]) begin
						st_nxt.enable = st_r.w_data[GPC_CTRL_EN_BIT];
					end
				end
				GPC_COUNT_OFS[7:2]: begin
					wr_hit = 1'b1;
				end
				GPC_LAST_ERR_OFS[7:2], GPC_LAST_CAUSE_OFS[7:2]: begin
				end
				default: begin
					st_nxt.bresp = 2'b10;
				end
			endcase
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (ar_go) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = 2'b00;
			unique case (s_axi_araddr[7:2])
				GPC_CTRL_OFS[7:2]:       st_nxt.rdata = {31'h0, st_r.enable};
				GPC_COUNT_OFS[7:2]:      st_nxt.rdata = st_r.count;
				GPC_LAST_ERR_OFS[7:2]:   st_nxt.rdata = st_r.last_err;
				GPC_LAST_CAUSE_OFS[7:2]: st_nxt.rdata = 32'(st_r.last_cause);
				default: begin
					st_nxt.rdata = 32'h0;
					st_nxt.rresp = 2'b10;
				end
			endcase
		end else if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		// Fault report: one pulse per violating request
		st_nxt.flt = raise;
		if (raise) begin
			st_nxt.cs       = insn_cs;
			st_nxt.ip       = insn_ip;
			st_nxt.new_task = ts_active && ts_committed;
			if (dlv_cause) begin
				st_nxt.err = {21'h0, dlv_vector, GPC_ERR_IDT_FLAG};
			end else if (desc_cause) begin
				st_nxt.err = {16'h0, desc_selector};
			end else begin
				st_nxt.err = GPC_ERR_NONE;
			end
			st_nxt.last_cause = cause;
		end
		// A fault in the clearing cycle is still counted
		if (wr_hit) begin
			st_nxt.count = raise ? 32'h1 : 32'h0;
		end else if (raise) begin
			st_nxt.count = st_r.count + 32'h1;
		end
		if (st_r.flt) begin
			st_nxt.last_err = st_r.err;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r        <= '0;
			st_r.enable <= GPC_CTRL_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// =====================================================================
	// Outputs
	assign s_axi_awready            = !st_r.aw_held && !st_r.bvalid;
	assign s_axi_wready             = !st_r.w_held && !st_r.bvalid;
	assign s_axi_bvalid             = st_r.bvalid;
	assign s_axi_bresp              = st_r.bresp;
	assign s_axi_arready            = !st_r.rvalid;
	assign s_axi_rvalid             = st_r.rvalid;
	assign s_axi_rresp              = st_r.rresp;
	assign s_axi_rdata              = st_r.rdata;
	assign general_protection_fault = st_r.flt;
	assign flt_vector               = st_r.flt ? GPC_VECTOR : 8'h00;
	assign flt_errcode_valid        = st_r.flt;
	assign flt_errcode              = st_r.err;
	assign flt_cs                   = st_r.cs;
	assign flt_ip                   = st_r.ip;
	assign flt_load_new_task        = st_r.flt && st_r.new_task;

	// =====================================================================
	// Checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	vector_report_a: assert property (
		general_protection_fault |-> flt_vector == 8'h0d && flt_errcode_valid)
		else $error("fault not reported as vector 13");
	defer_other_a: assert property (
		req_valid && other_fault |=> !general_protection_fault)
		else $error("fault raised despite specific exception");
	length_limit_a: assert property (
		st_r.enable && req_valid && !other_fault && insn_len == 5'h10
		|=> general_protection_fault)
		else $error("sixteen byte instruction not faulted");
	length_ok_a: assert property (
		req_valid && insn_len == 5'h0f && (cause & ~22'h40) == '0 |=> !general_protection_fault)
		else $error("fifteen bytes counted as overrun");
	priv_level_a: assert property (
		st_r.enable && req_valid && !other_fault && privileged_insn
		&& current_privilege_level == 2'h1 |=> general_protection_fault)
		else $error("privileged insn at level 1 not faulted");
	zero_code_a: assert property (
		raise && !desc_cause && !dlv_cause |=> flt_errcode == 32'h0)
		else $error("nonzero code for non-descriptor fault");
	selector_code_a: assert property (
		raise && !dlv_cause && cause[4] |=> flt_errcode[15:0] == $past(desc_selector))
		else $error("selector missing from error code");
	fault_site_a: assert property (
		raise |=> flt_ip == $past(insn_ip) && flt_cs == $past(insn_cs))
		else $error("wrong faulting instruction pointer");
	commit_point_a: assert property (
		raise && ts_active && !ts_committed |=> !flt_load_new_task)
		else $error("pre-commit fault loads new task");
	nested_interrupt_return_instruction_a: assert property (
		st_r.enable && req_valid && !other_fault && mode_64
		&& interrupt_return_instruction && nested_task_flag
		|=> general_protection_fault ##1 !general_protection_fault || req_valid)
		else $error("interrupt_return_instruction with nested task not faulted");
	align_chk_a: assert property (
		st_r.enable && req_valid && !other_fault && acc_valid && acc_vec_aligned
		&& acc_addr[3:0] == 4'h8 |=> general_protection_fault)
		else $error("misaligned vector operand not faulted");

endmodule : gpc_checker

// ===== verif/gpc_dlv_model.sv
`timescale 1ns/1ps
// =====================================================================
// Exception delivery side: takes each reported fault
module gpc_dlv_model
	import gpc_pkg::*;
(
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Fault report
	input  wire logic       general_protection_fault,
	input  wire logic [7:0] flt_vector,
	input  wire logic       flt_errcode_valid,
	// Tallies
	output int              n_taken,
	output int              n_bad
);
	always @(posedge aclk) begin
		if (!aresetn) begin
			n_taken <= 0;
			n_bad   <= 0;
		end else if (general_protection_fault === 1'b1) begin
			n_taken <= n_taken + 1;
			// Delivery cannot route a fault without vector and code
			if (flt_vector !== GPC_VECTOR || flt_errcode_valid !== 1'b1)
				n_bad <= n_bad + 1;
		end
	end
endmodule : gpc_dlv_model

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench
	import gpc_pkg::*;
;
	// =====================================================================
	// Signals
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, flt_vector, dlv_vector;
	logic [31:0] s_axi_wdata, s_axi_rdata, flt_errcode;
	logic [3:0]  s_axi_wstrb, dlv_gate_type;
	logic [1:0]  s_axi_bresp, s_axi_rresp, current_privilege_level, swint_gate_dpl;
	logic [1:0]  gate64_dpl, gate64_rpl;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        req_valid, other_fault, mode_64, long_mode_active, privileged_insn;
	logic        acc_valid, acc_via_ss, acc_write, acc_over_limit, acc_seg_code;
	logic        acc_seg_writable, acc_seg_readable, acc_seg_null, acc_vec_aligned;
	logic        ld_null, ld_desc_exec, desc_addr_valid, cr_wr_valid, swint_insn, dlv_valid;
	logic        interrupt_return_instruction, nested_task_flag, gate64_valid, far_valid;
	logic        far_tgt_long, far_tgt_dsize, ts_active, ts_committed;
	logic        general_protection_fault, flt_errcode_valid, flt_load_new_task;
	logic [15:0] insn_cs, desc_selector, flt_cs;
	logic [63:0] insn_ip, acc_addr, desc_addr, cr_wdata, msr_rsvd_mask, far_offset, flt_ip;
	logic [4:0]  insn_len, gate64_upper_type;
	gpc_ld_t     ld_target;
	gpc_cr_t     cr_sel;
	int          num_errors = 0, checks = 0, exp_cnt = 0, n_taken, n_bad;

	gpc_checker u_dut (.*);
	gpc_dlv_model u_dlv (.aclk(aclk), .aresetn(aresetn),
		.general_protection_fault(general_protection_fault), .flt_vector(flt_vector),
		.flt_errcode_valid(flt_errcode_valid), .n_taken(n_taken), .n_bad(n_bad));

	always #5 aclk = ~aclk;

	// =====================================================================
	// Common tasks
	task stop_test;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : stop_test

	task cmp(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : cmp

	task quit(input int n);
		if (n >= 50) begin
			num_errors++;
			stop_test();
		end
	endtask : quit

	// Benign context: every check passes with these values
	task dflt;
		{req_valid, other_fault, mode_64, long_mode_active, privileged_insn} <= '0;
		{acc_valid, acc_via_ss, acc_write, acc_over_limit, acc_seg_code} <= '0;
		{acc_seg_null, acc_vec_aligned, ld_null, ld_desc_exec, desc_addr_valid} <= '0;
		{cr_wr_valid, swint_insn, dlv_valid, interrupt_return_instruction} <= '0;
		{nested_task_flag, gate64_valid, far_valid, far_tgt_long, far_tgt_dsize} <= '0;
		{ts_active, ts_committed, acc_seg_writable, acc_seg_readable} <= 4'h3;
		current_privilege_level <= 2'h0;
		insn_cs <= 16'h0008;
		insn_ip <= 64'h1000;
		insn_len <= 5'h03;
		acc_addr <= 64'h2000;
		ld_target <= GPC_LD_NONE;
		desc_selector <= 16'h0010;
		desc_addr <= 64'h0;
		cr_sel <= GPC_CR_CR0;
		cr_wdata <= 64'h1;
		msr_rsvd_mask <= 64'hff00;
		swint_gate_dpl <= 2'h0;
		dlv_vector <= 8'h20;
		dlv_gate_type <= GPC_GATE_INT;
		{gate64_upper_type, gate64_dpl, gate64_rpl} <= '0;
		far_offset <= 64'h0;
	endtask : dflt

	// One request with the context set up at this edge
	task chk(input logic f, input logic [31:0] e, input logic t = 1'b0);
		req_valid <= 1'b1;
		@(posedge aclk);
		dflt();
		#1;
		cmp(general_protection_fault, f);
		if (f) begin
			exp_cnt++;
			cmp(flt_vector, GPC_VECTOR);
			cmp(flt_errcode_valid, 1'b1);
			cmp(flt_errcode, e);
			cmp(flt_load_new_task, t);
		end
		@(posedge aclk);
	endtask : chk

	task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit pa, pw, ta, tw;
		int n;
		{pa, pw, n} = {2'b11, 32'd0};
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while ((pa || pw) && n < 50) begin
			@(negedge aclk);
			n++;
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			@(posedge aclk);
			if (ta) {pa, s_axi_awvalid} <= 2'b00;
			if (tw) {pw, s_axi_wvalid} <= 2'b00;
		end
		do begin
			@(negedge aclk);
			n++;
		end while (!s_axi_bvalid && n < 50);
		quit(n);
		cmp(s_axi_bresp, er);
		@(posedge aclk);
		s_axi_bready <= 1'b0;
		// Next request must not retouch bready in this time step
		@(posedge aclk);
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(negedge aclk);
			n++;
		end while (!s_axi_arready && n < 50);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			n++;
		end while (!s_axi_rvalid && n < 50);
		quit(n);
		cmp(s_axi_rresp, er);
		cmp(s_axi_rdata, d);
		@(posedge aclk);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : axi_rd

	// =====================================================================
	// Scenarios
	task t_length;
		insn_len <= 5'h10; insn_cs <= 16'h0023; insn_ip <= 64'h4444;
		chk(1'b1, GPC_ERR_NONE);
		cmp(flt_cs, 16'h0023);
		cmp(flt_ip, 64'h4444);
		insn_len <= GPC_MAX_LEN;
		chk(1'b0, 0);
		insn_len <= 5'h10; other_fault <= 1'b1;
		chk(1'b0, 0);
		cmp(flt_ip, 64'h4444);
	endtask : t_length

	task t_segment;
		{acc_valid, acc_over_limit} <= 2'b11;
		chk(1'b1, 0);
		{acc_valid, acc_over_limit, acc_via_ss} <= 3'h7;
		chk(1'b0, 0);
		{acc_valid, acc_write, acc_seg_code} <= 3'h7;
		chk(1'b1, 0);
		{acc_valid, acc_write, acc_seg_writable} <= 3'h6;
		chk(1'b1, 0);
		{acc_valid, acc_seg_code, acc_seg_readable} <= 3'h6;
		chk(1'b1, 0);
		{acc_valid, acc_seg_null} <= 2'b11;
		chk(1'b1, 0);
		{acc_valid, acc_vec_aligned, acc_via_ss} <= 3'h7; acc_addr <= 64'h2008;
		chk(1'b1, 0);
		{acc_valid, acc_vec_aligned} <= 2'b11; acc_addr <= 64'h2010;
		chk(1'b0, 0);
	endtask : t_segment

	task t_load;
		ld_target <= GPC_LD_SS; ld_null <= 1'b1;
		chk(1'b1, 32'h10);
		ld_target <= GPC_LD_SS; ld_desc_exec <= 1'b1;
		chk(1'b1, 32'h10);
		ld_target <= GPC_LD_CS;
		chk(1'b1, 32'h10);
		ld_target <= GPC_LD_CS; ld_desc_exec <= 1'b1;
		chk(1'b0, 0);
	endtask : t_load

	task t_ctrl;
		logic [65:0] tab [10];
		tab = '{{GPC_CR_CR0, 64'h8000_0000}, {GPC_CR_CR0, 64'h2000_0001},
			{GPC_CR_CR0, 64'h6000_0001}, {GPC_CR_CR0, 64'h8000_0001},
			{GPC_CR_CR4, 64'h1000}, {GPC_CR_CR4, 64'h20}, {GPC_CR_MSR, 64'h100},
			{GPC_CR_MSR, 64'hff}, {GPC_CR_VCSR, 64'h1_0000}, {GPC_CR_VCSR, 64'hffff}};
		foreach (tab[i]) begin
			cr_wr_valid <= 1'b1;
			{cr_sel, cr_wdata} <= tab[i];
			chk(i % 2 == 0 && i != 2 || i == 1, 0);
		end
		{cr_wr_valid, long_mode_active} <= 2'b11; cr_wdata <= 64'h1;
		chk(1'b1, 0);
	endtask : t_ctrl

	task t_priv;
		logic [3:0] ok [5];
		ok = '{GPC_GATE_TASK, GPC_GATE_INT16, GPC_GATE_TRAP16, GPC_GATE_INT, GPC_GATE_TRAP};
		privileged_insn <= 1'b1; current_privilege_level <= 2'h3;
		chk(1'b1, 0);
		privileged_insn <= 1'b1;
		chk(1'b0, 0);
		swint_insn <= 1'b1; current_privilege_level <= 2'h3; swint_gate_dpl <= 2'h2;
		chk(1'b1, 0);
		swint_insn <= 1'b1; current_privilege_level <= 2'h2; swint_gate_dpl <= 2'h2;
		chk(1'b0, 0);
		foreach (ok[i]) begin
			dlv_valid <= 1'b1; dlv_gate_type <= ok[i];
			chk(1'b0, 0);
		end
		dlv_valid <= 1'b1; dlv_gate_type <= 4'hc;
		chk(1'b1, 32'h0000_0102);
	endtask : t_priv

	task t_mode64;
		{mode_64, acc_valid} <= 2'b11; acc_addr <= 64'h0000_8000_0000_0000;
		chk(1'b1, 0);
		{mode_64, acc_valid} <= 2'b11; acc_addr <= 64'hffff_8000_0000_0000;
		chk(1'b0, 0);
		{mode_64, interrupt_return_instruction, nested_task_flag} <= 3'h7;
		chk(1'b1, 0);
		{mode_64, gate64_valid, gate64_upper_type} <= {2'b11, 5'h01};
		chk(1'b1, 32'h10);
		{mode_64, gate64_valid, gate64_dpl} <= {2'b11, 2'h1}; current_privilege_level <= 2'h2;
		chk(1'b1, 32'h10);
		{mode_64, gate64_valid, gate64_dpl, gate64_rpl} <= {2'b11, 4'h6};
		chk(1'b1, 32'h10);
		{mode_64, gate64_valid, gate64_dpl, gate64_rpl} <= {2'b11, 4'hf};
		chk(1'b0, 0);
		{mode_64, far_valid, far_tgt_long, far_tgt_dsize} <= 4'hf;
		chk(1'b1, 32'h10);
	endtask : t_mode64

	task t_task;
		{ts_active, ts_committed} <= 2'b11; insn_len <= 5'h10;
		chk(1'b1, 0, 1'b1);
		ts_active <= 1'b1; insn_len <= 5'h10;
		chk(1'b1, 0, 1'b0);
	endtask : t_task

	task t_regs;
		axi_wr(GPC_CTRL_OFS, 32'h0, 2'h0);
		insn_len <= 5'h10;
		chk(1'b0, 0);
		axi_wr(GPC_CTRL_OFS, 32'h1, 2'h0);
		// Last fault carries a selector so the log registers show it
		ld_target <= GPC_LD_CS;
		chk(1'b1, 32'h10);
		axi_rd(GPC_COUNT_OFS, exp_cnt, 2'h0);
		axi_rd(GPC_LAST_ERR_OFS, 32'h10, 2'h0);
		axi_rd(GPC_LAST_CAUSE_OFS, 32'h10, 2'h0);
		axi_rd(8'h10, 32'h0, 2'h2);
		axi_wr(8'h14, 32'h1, 2'h2);
	endtask : t_regs

	// =====================================================================
	// Main sequence
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		dflt();
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_rd(GPC_CTRL_OFS, 32'h1, 2'h0);
		axi_wr(GPC_COUNT_OFS, 32'h0, 2'h0);
		t_length();
		t_segment();
		t_load();
		t_ctrl();
		t_priv();
		t_mode64();
		t_task();
		t_regs();
		cmp(n_taken, exp_cnt);
		cmp(n_bad, 0);
		stop_test();
	end
endmodule : testbench
